// ---- logic/psw_top.sv ----
// Settings packet decoder, power-up loader, pin mux and register slave
//
// Overview of operation
// RULE1 - Byte0 0xb1 with byte1 0x00 stores chip settings from following bytes.
// RULE2 - Undefined subcode yields unsupported status as response code.
// RULE3 - Byte5 bit6 set: falling interrupt-input edge sets detection flag.
// RULE4 - Byte5 bit5 set: rising interrupt-input edge sets detection flag.
// RULE5 - Byte5 bits4-3 select converter reference level; 00 turns it off.
// RULE6 - Byte5 bit2 picks internal reference (1) or supply rail (0).
// RULE7 - Vendor id comes low byte first in bytes 6 and 7.
// RULE8 - Product id comes low byte first in bytes 8 and 9.
// RULE9 - Byte 10 is stored and presented as power attributes.
// RULE10 - Byte 11 stored; requested current is twice it in milliamperes.
// RULE11 - Bytes 12 to 19 are stored as the eight-byte password.
// RULE12 - Byte0 0xb1 with byte1 0x01 stores pin power-up settings.
// RULE13 - Pin byte bit4 is the output level at power-up for outputs.
// RULE14 - Pin byte bit3 sets direction, honoured only in general-purpose mode.
// RULE15 - First pin codes: general-purpose, receive indicator, suspend indicator.
// RULE16 - Second pin codes: gpio, clock, converter, transmit indicator, interrupt.
// RULE17 - Third pin codes: gpio, clock, converter input 2, analog output.
// RULE18 - Stored values applied at next power-up; don't-care bits ignored.
// RULE19 - Both edge bits catch either edge; neither catches none.
`timescale 1ns/1ps
module psw_top
  import psw_pkg::*;
#(
  parameter logic [7:0] RESP_UNSUPPORTED = 8'h01
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic pkt_valid,
  input wire logic [7:0] pkt_data,
  input wire logic pkt_last,
  output logic pkt_ready,
  output logic resp_valid,
  output logic [7:0] resp_status,
  input wire logic [2:0] pin_in,
  output logic [2:0] pin_out,
  output logic [2:0] pin_oe_n,
  input wire logic rx_activity,
  input wire logic tx_activity,
  input wire logic suspend_state,
  input wire logic clk_ref,
  output logic converter_input_1,
  output logic converter_input_2,
  output logic analog_output_1,
  output logic [1:0] conv_ref_sel,
  output logic internal_converter_reference,
  output logic [15:0] usb_vid,
  output logic [15:0] usb_pid,
  output logic [7:0] usb_power_attr,
  output logic [8:0] usb_current_ma,
  output logic [63:0] password,
  output logic settings_loaded,
  output logic irq
);
  psw_state_type state_q;
  logic [7:0] act_q [ST_ENTRIES];
  logic [4:0] load_cnt_q;
  logic rd_valid_q;
  logic [4:0] rd_idx_q;
  logic [7:0] rd_data;
  logic [5:0] idx_q;
  logic [7:0] cmd_q;
  logic [7:0] sub_q;
  logic [7:0] cmd_now;
  logic [7:0] sub_now;
  logic take;
  logic pkt_end;
  logic is_flash;
  logic unsup;
  logic st_we;
  logic [4:0] st_waddr;
  logic [7:0] st_wdata;
  logic [STAT_W-1:0] stat_q;
  logic [STAT_W-1:0] mask_q;
  logic [2:0] gpio_out_q;
  logic [2:0] pin_lvl;
  logic [2:0] pin_rise;
  logic [2:0] pin_fall;
  logic edge_hit;
  logic ack_q;
  logic acc;
  logic reload_req;
  logic [2:0] fn [NUM_PINS];

  ////////////////////////////////////////////////////////////////////////////
  // Store and pin synchroniser
  psw_store #(.AW(ST_AW), .DW(8)) u_store (
    .clk(clk),
    .we(st_we),
    .waddr(st_waddr),
    .wdata(st_wdata),
    .raddr(load_cnt_q),
    .rdata_q(rd_data)
  );

  psw_sync_edge #(.W(NUM_PINS)) u_pins (
    .clk(clk),
    .rstn(rstn),
    .async_i(pin_in),
    .level_q(pin_lvl),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Power-up load: store contents become the active settings
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_LOAD;
      load_cnt_q <= '0;
    end else begin
      unique case (state_q)
        ST_LOAD: begin
          load_cnt_q <= load_cnt_q + 5'h01;
          if (load_cnt_q == ST_LOAD_LAST) begin
            state_q <= ST_SETTLE;
          end
        end
        ST_SETTLE: state_q <= ST_APPLY;
        ST_APPLY: state_q <= ST_RUN;
        ST_RUN: begin
          load_cnt_q <= '0;
          if (reload_req) begin
            state_q <= ST_LOAD;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_valid_q <= 1'b0;
      rd_idx_q <= '0;
    end else begin
      rd_valid_q <= (state_q == ST_LOAD);
      rd_idx_q <= load_cnt_q;
    end
  end

  // Active values change only on load, so a packet never alters live pins
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < ST_ENTRIES; i++) begin
        act_q[i] <= 8'h00;
      end
    end else if (rd_valid_q) begin
      act_q[rd_idx_q] <= rd_data; // RULE18
    end
  end

  assign settings_loaded = (state_q == ST_RUN);
  assign conv_ref_sel = act_q[ST_CHIP][REF_SEL_HI:REF_SEL_LO]; // RULE5
  assign internal_converter_reference = act_q[ST_CHIP][REF_SRC_BIT]; // RULE6
  assign usb_vid = {act_q[ST_VID_HI], act_q[ST_VID_LO]}; // RULE7
  assign usb_pid = {act_q[ST_PID_HI], act_q[ST_PID_LO]}; // RULE8
  assign usb_power_attr = act_q[ST_POWER]; // RULE9
  assign usb_current_ma = {act_q[ST_CURRENT], 1'b0}; // RULE10

  generate
    for (genvar g = 0; g < 8; g++) begin : g_pass
      assign password[g*8 +: 8] = act_q[ST_PASS + 5'(g)]; // RULE11
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Packet decode into the store
  assign pkt_ready = (state_q == ST_RUN);
  assign take = pkt_valid && pkt_ready;
  assign pkt_end = take && (pkt_last || idx_q == IDX_LAST);
  assign cmd_now = (idx_q == 6'h00) ? pkt_data : cmd_q;
  assign sub_now = (idx_q == 6'h01) ? pkt_data : sub_q;
  assign is_flash = (cmd_now == CMD_WRITE_FLASH);
  assign unsup = is_flash && (sub_now > SUB_LAST_DEFINED); // RULE2

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      idx_q <= '0;
      cmd_q <= 8'h00;
      sub_q <= 8'h00;
    end else if (take) begin
      idx_q <= pkt_end ? 6'h00 : idx_q + 6'h01;
      cmd_q <= cmd_now;
      sub_q <= sub_now;
    end
  end

  // Short packets store what arrived; later bytes keep their old values
  always_comb begin
    st_we = 1'b0;
    st_waddr = '0;
    st_wdata = 8'h00;
    if (take && is_flash && idx_q >= GP_FIRST) begin
      if (sub_now == SUB_CHIP && idx_q >= CHIP_FIRST && idx_q <= CHIP_LAST) begin
        st_we = 1'b1; // RULE1
        st_waddr = 5'(idx_q - CHIP_FIRST);
        st_wdata = (idx_q == CHIP_FIRST) ? (pkt_data & CHIP_MASK) : pkt_data; // RULE18
      end else if (sub_now == SUB_GP && idx_q <= GP_LAST) begin
        st_we = 1'b1; // RULE12
        st_waddr = 5'(idx_q + GP_TO_ST);
        st_wdata = pkt_data & GP_MASK; // RULE18
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      resp_valid <= 1'b0;
      resp_status <= RESP_OK;
    end else begin
      resp_valid <= pkt_end && is_flash;
      if (pkt_end && is_flash) begin
        resp_status <= unsup ? RESP_UNSUPPORTED : RESP_OK; // RULE2
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin multiplexer
  generate
    for (genvar p = 0; p < NUM_PINS; p++) begin : g_fn
      assign fn[p] = act_q[ST_GP + 5'(p)][2:0];
    end
  endgenerate

  // Returns {drive, level}; codes with no meaning leave the pin undriven
  function automatic logic [1:0] drive_f(input int pin, input logic [2:0] code, input logic dir,
                                         input logic lvl);
    logic [1:0] r;
    r = 2'b00;
    if (code == FN_GPIO) begin
      r = {~dir, lvl}; // RULE14
    end else if (pin == 0) begin
      if (code == P0_RX_LED) r = {1'b1, rx_activity}; // RULE15
      if (code == P0_SUSPEND) r = {1'b1, suspend_state}; // RULE15
    end else begin
      if (code == P12_CLK) r = {1'b1, clk_ref}; // RULE16 RULE17
      if (pin == 1 && code == P1_TX_LED) r = {1'b1, tx_activity}; // RULE16
    end
    return r;
  endfunction

  generate
    for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
      logic [1:0] drv;
      assign drv = drive_f(p, fn[p], act_q[ST_GP + 5'(p)][GP_DIR_BIT], gpio_out_q[p]);
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          pin_out[p] <= 1'b0;
          pin_oe_n[p] <= 1'b1;
        end else begin
          pin_out[p] <= drv[0];
          pin_oe_n[p] <= ~drv[1];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      converter_input_1 <= 1'b0;
      converter_input_2 <= 1'b0;
      analog_output_1 <= 1'b0;
    end else begin
      converter_input_1 <= (fn[1] == P12_CONV); // RULE16
      converter_input_2 <= (fn[2] == P12_CONV); // RULE17
      analog_output_1 <= (fn[2] == P2_ANALOG); // RULE17
    end
  end

  // Interrupt input only counts when the second pin is set for it
  assign edge_hit = (fn[1] == P1_INT) &&
    ((act_q[ST_CHIP][NEG_EDGE_BIT] && pin_fall[1]) || // RULE3 RULE19
     (act_q[ST_CHIP][POS_EDGE_BIT] && pin_rise[1])); // RULE4 RULE19

  ////////////////////////////////////////////////////////////////////////////
  // Avalon slave: one wait cycle, registered read data
  assign acc = (avs_read || avs_write) && ack_q;
  assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
  assign reload_req = acc && avs_write && avs_address == REG_CONTROL && avs_writedata[CTRL_RELOAD];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read || avs_write) && !ack_q;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      avs_readdata <= '0;
    end else if ((avs_read || avs_write) && !ack_q) begin
      unique case (avs_address)
        REG_STATUS: avs_readdata <= 32'(stat_q);
        REG_MASK: avs_readdata <= 32'(mask_q);
        REG_GPIO_OUT: avs_readdata <= 32'(gpio_out_q);
        REG_GPIO_IN: avs_readdata <= 32'(pin_lvl);
        REG_IDS: avs_readdata <= {usb_pid, usb_vid};
        REG_POWER: avs_readdata <= {12'h000, settings_loaded, internal_converter_reference,
                                    conv_ref_sel, usb_current_ma[8:1], usb_power_attr};
        default: avs_readdata <= '0;
      endcase
    end
  end

  // Set wins over the read clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stat_q <= '0;
    end else begin
      for (int i = 0; i < STAT_W; i++) begin
        if (acc && avs_read && avs_address == REG_STATUS) stat_q[i] <= 1'b0;
      end
      if (edge_hit) stat_q[STAT_EDGE] <= 1'b1; // RULE3 RULE4
      if (pkt_end && is_flash && !unsup) stat_q[STAT_STORED] <= 1'b1;
      if (pkt_end && unsup) stat_q[STAT_UNSUP] <= 1'b1; // RULE2
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mask_q <= MASK_RST;
    end else if (acc && avs_write && avs_address == REG_MASK) begin
      mask_q <= avs_writedata[STAT_W-1:0];
    end
  end

  // Power-up level comes from the store; software may change it later
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gpio_out_q <= GPIO_OUT_RST;
    end else if (state_q == ST_APPLY) begin
      for (int p = 0; p < NUM_PINS; p++) begin
        gpio_out_q[p] <= act_q[ST_GP + 5'(p)][GP_LVL_BIT]; // RULE13
      end
    end else if (acc && avs_write && avs_address == REG_GPIO_OUT) begin
      gpio_out_q <= avs_writedata[2:0];
    end
  end

  assign irq = |(stat_q & mask_q);

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  sequence s_unsup_end;
    pkt_end && unsup;
  endsequence
  sequence s_resp_unsup;
    resp_valid && resp_status == RESP_UNSUPPORTED;
  endsequence
  property p_unsup;
    @(posedge clk) disable iff (!rstn) s_unsup_end |=> s_resp_unsup ##1 !resp_valid;
  endproperty
  a_unsup: assert property (p_unsup) else $error("unsupported subcode not reported"); // RULE2
  property p_fall;
    @(posedge clk) disable iff (!rstn)
      (fn[1] == P1_INT && act_q[ST_CHIP][NEG_EDGE_BIT] && pin_fall[1]) |=> stat_q[STAT_EDGE];
  endproperty
  a_fall: assert property (p_fall) else $error("falling edge missed"); // RULE3
  property p_rise;
    @(posedge clk) disable iff (!rstn)
      (fn[1] == P1_INT && act_q[ST_CHIP][POS_EDGE_BIT] && pin_rise[1]) |=> stat_q[STAT_EDGE];
  endproperty
  a_rise: assert property (p_rise) else $error("rising edge missed"); // RULE4
  property p_noedge;
    @(posedge clk) disable iff (!rstn)
      (act_q[ST_CHIP][6:5] == 2'b00 && !stat_q[STAT_EDGE] && !rd_valid_q) |=> !stat_q[STAT_EDGE];
  endproperty
  a_noedge: assert property (p_noedge) else $error("edge flag set while disabled"); // RULE19
  property p_chip_pass;
    @(posedge clk) disable iff (!rstn)
      (take && cmd_q == CMD_WRITE_FLASH && sub_q == SUB_CHIP && idx_q == 6'h0c) |-> st_we && st_waddr == ST_PASS;
  endproperty
  a_chip_pass: assert property (p_chip_pass) else $error("password byte not stored"); // RULE11
  property p_gp_store;
    @(posedge clk) disable iff (!rstn)
      (take && cmd_q == CMD_WRITE_FLASH && sub_q == SUB_GP && idx_q == 6'h03)
        |-> st_we && st_waddr == 5'h10 && st_wdata[7:5] == 3'h0;
  endproperty
  a_gp_store: assert property (p_gp_store) else $error("pin byte not stored"); // RULE12
  property p_chip_mask;
    @(posedge clk) disable iff (!rstn) (st_we && st_waddr == ST_CHIP) |-> (st_wdata & ~CHIP_MASK) == 8'h00;
  endproperty
  a_chip_mask: assert property (p_chip_mask) else $error("don't-care bits stored"); // RULE18
  property p_level;
    @(posedge clk) disable iff (!rstn) state_q == ST_APPLY |=> gpio_out_q[0] == act_q[ST_GP][GP_LVL_BIT];
  endproperty
  a_level: assert property (p_level) else $error("power-up level not applied"); // RULE13
  property p_dir;
    @(posedge clk) disable iff (!rstn)
      (fn[2] == FN_GPIO && act_q[ST_GP + 5'h02][GP_DIR_BIT] && state_q == ST_RUN) ##1 $stable(act_q[ST_GP + 5'h02])
        |=> pin_oe_n[2];
  endproperty
  a_dir: assert property (p_dir) else $error("input pin driven"); // RULE14
  property p_clk1;
    @(posedge clk) disable iff (!rstn) fn[1] == P12_CLK |=> !pin_oe_n[1] && pin_out[1] == $past(clk_ref);
  endproperty
  a_clk1: assert property (p_clk1) else $error("clock output missing"); // RULE16
  property p_ma;
    @(posedge clk) disable iff (!rstn) rd_valid_q && rd_idx_q == ST_CURRENT |=> usb_current_ma == {$past(rd_data), 1'b0};
  endproperty
  a_ma: assert property (p_ma) else $error("current request wrong"); // RULE10
endmodule

// ---- logic/psw_pkg.sv ----
// Constants and types shared by the power-up settings writer
package psw_pkg;
  localparam logic [7:0] CMD_WRITE_FLASH = 8'hb1;
  localparam logic [7:0] SUB_CHIP = 8'h00;
  localparam logic [7:0] SUB_GP = 8'h01;
  localparam logic [7:0] SUB_LAST_DEFINED = 8'h04;
  localparam logic [7:0] RESP_OK = 8'h00;
  localparam int PKT_BYTES = 64;
  localparam int IDX_W = 6;
  localparam logic [5:0] IDX_LAST = 6'h3f;
  localparam logic [5:0] CHIP_FIRST = 6'h05;
  localparam logic [5:0] CHIP_LAST = 6'h13;
  localparam logic [5:0] GP_FIRST = 6'h02;
  localparam logic [5:0] GP_LAST = 6'h04;
  // Store layout
  localparam int ST_AW = 5;
  localparam int ST_ENTRIES = 18;
  localparam logic [4:0] ST_CHIP = 5'h00;
  localparam logic [4:0] ST_VID_LO = 5'h01;
  localparam logic [4:0] ST_VID_HI = 5'h02;
  localparam logic [4:0] ST_PID_LO = 5'h03;
  localparam logic [4:0] ST_PID_HI = 5'h04;
  localparam logic [4:0] ST_POWER = 5'h05;
  localparam logic [4:0] ST_CURRENT = 5'h06;
  localparam logic [4:0] ST_PASS = 5'h07;
  localparam logic [4:0] ST_GP = 5'h0f;
  localparam logic [4:0] ST_LOAD_LAST = 5'h11;
  localparam logic [5:0] GP_TO_ST = 6'h0d;
  // Field positions and masks
  localparam int NEG_EDGE_BIT = 6;
  localparam int POS_EDGE_BIT = 5;
  localparam int REF_SEL_HI = 4;
  localparam int REF_SEL_LO = 3;
  localparam int REF_SRC_BIT = 2;
  localparam logic [7:0] CHIP_MASK = 8'h7c;
  localparam int GP_LVL_BIT = 4;
  localparam int GP_DIR_BIT = 3;
  localparam logic [7:0] GP_MASK = 8'h1f;
  localparam int NUM_PINS = 3;
  // Pin function codes
  localparam logic [2:0] FN_GPIO = 3'h0;
  localparam logic [2:0] P0_RX_LED = 3'h1;
  localparam logic [2:0] P0_SUSPEND = 3'h2;
  localparam logic [2:0] P12_CLK = 3'h1;
  localparam logic [2:0] P12_CONV = 3'h2;
  localparam logic [2:0] P1_TX_LED = 3'h3;
  localparam logic [2:0] P1_INT = 3'h4;
  localparam logic [2:0] P2_ANALOG = 3'h3;
  // Register word indices
  localparam logic [2:0] REG_STATUS = 3'h0;
  localparam logic [2:0] REG_MASK = 3'h1;
  localparam logic [2:0] REG_GPIO_OUT = 3'h2;
  localparam logic [2:0] REG_GPIO_IN = 3'h3;
  localparam logic [2:0] REG_IDS = 3'h4;
  localparam logic [2:0] REG_POWER = 3'h5;
  localparam logic [2:0] REG_CONTROL = 3'h6;
  localparam int STAT_EDGE = 0;
  localparam int STAT_STORED = 1;
  localparam int STAT_UNSUP = 2;
  localparam int STAT_W = 3;
  localparam int CTRL_RELOAD = 0;
  localparam logic [2:0] MASK_RST = 3'h0;
  localparam logic [2:0] GPIO_OUT_RST = 3'h0;
  typedef enum logic [1:0] {ST_LOAD, ST_SETTLE, ST_APPLY, ST_RUN} psw_state_type;
endpackage

// ---- logic/psw_store.sv ----
// Nonvolatile settings store model with registered read data
`timescale 1ns/1ps
module psw_store #(
  parameter int AW = 5,
  parameter int DW = 8
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata_q
);
  logic [DW-1:0] mem [2**AW];

  // Blank part reads as zero; contents survive rstn on purpose
  initial begin
    for (int i = 0; i < 2**AW; i++) begin
      mem[i] = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_q <= mem[raddr];
  end
endmodule

// ---- logic/psw_sync_edge.sv ----
// Two-stage synchroniser with edge pulses
`timescale 1ns/1ps
module psw_sync_edge #(
  parameter int W = 3
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] level_q,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  logic [W-1:0] meta_q;
  logic [W-1:0] prev_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= '0;
      level_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= async_i;
      level_q <= meta_q;
      prev_q <= level_q;
    end
  end

  assign rise = level_q & ~prev_q;
  assign fall = ~level_q & prev_q;
endmodule

// ---- sim/psw_host_model.sv ----
// Host model that sends 64-byte settings packets and counts the replies
`timescale 1ns/1ps
module psw_host_model
  import psw_pkg::*;
(
  input wire logic clk,
  input wire logic pkt_ready,
  input wire logic resp_valid,
  input wire logic [7:0] resp_status,
  output logic pkt_valid,
  output logic [7:0] pkt_data,
  output logic pkt_last
);
  logic [7:0] pkt_q [64];
  logic [7:0] resp_n = 8'h00;
  logic [7:0] resp_code = 8'h00;
  logic valid_d = 1'b0;
  initial begin
    pkt_valid = 1'b0;
    pkt_data = 8'h5a;
    pkt_last = 1'b0;
  end
  always @(posedge clk) begin
    valid_d <= pkt_valid;
    // A new packet restarts the reply count
    if (pkt_valid && !valid_d) begin
      resp_n <= 8'h00;
    end else if (resp_valid === 1'b1) begin
      resp_n <= resp_n + 8'h01;
      resp_code <= resp_status;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Each byte is held until an edge that sees ready high
  task automatic send();
    for (int i = 0; i < PKT_BYTES; i++) begin
      @(posedge clk);
      pkt_valid <= 1'b1;
      pkt_data <= pkt_q[i];
      pkt_last <= (i == PKT_BYTES - 1);
      @(negedge clk);
      while (pkt_ready !== 1'b1) @(negedge clk);
    end
    @(posedge clk);
    pkt_valid <= 1'b0;
    pkt_last <= 1'b0;
    // Released byte lane must not keep showing the last byte
    pkt_data <= ~pkt_data;
    repeat (3) @(posedge clk);
  endtask
  task automatic fill(input logic [7:0] sub);
    pkt_q[0] = CMD_WRITE_FLASH;
    pkt_q[1] = sub;
    for (int i = 2; i < PKT_BYTES; i++) pkt_q[i] = 8'hff;
  endtask
  task automatic chip(input logic [7:0] sub, input logic [7:0] b5, input logic [15:0] vid,
      input logic [15:0] pid, input logic [7:0] pwr, input logic [7:0] cur, input logic [63:0] pw);
    fill(sub);
    pkt_q[5] = b5;
    pkt_q[6] = vid[7:0];
    pkt_q[7] = vid[15:8];
    pkt_q[8] = pid[7:0];
    pkt_q[9] = pid[15:8];
    pkt_q[10] = pwr;
    pkt_q[11] = cur;
    for (int k = 0; k < 8; k++) pkt_q[12 + k] = pw[8*k +: 8];
    send();
  endtask
  task automatic gp(input logic [7:0] b2, input logic [7:0] b3, input logic [7:0] b4);
    fill(SUB_GP);
    pkt_q[2] = b2;
    pkt_q[3] = b3;
    pkt_q[4] = b4;
    send();
  endtask
endmodule

// ---- sim/psw_top_bench.sv ----
// Self-checking bench for the power-up settings writer
`timescale 1ns/1ps
module psw_top_bench
  import psw_pkg::*;
;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [2:0] avs_address = 3'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, pkt_valid, pkt_last, pkt_ready, resp_valid, irq, settings_loaded;
  logic [7:0] pkt_data, resp_status, usb_power_attr;
  logic [2:0] pin_in = 3'h0;
  logic rx_activity = 1'b0, tx_activity = 1'b0, suspend_state = 1'b0, clk_ref = 1'b0;
  logic [2:0] pin_out, pin_oe_n;
  logic converter_input_1, converter_input_2, analog_output_1, internal_converter_reference;
  logic [1:0] conv_ref_sel;
  logic [15:0] usb_vid, usb_pid;
  logic [8:0] usb_current_ma;
  logic [63:0] password;
  int err_total = 0;
  int samples_checked = 0;
  always #12.5 clk = ~clk;
  psw_top u_psw_top (.clk(clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .pkt_valid(pkt_valid), .pkt_data(pkt_data), .pkt_last(pkt_last),
    .pkt_ready(pkt_ready), .resp_valid(resp_valid), .resp_status(resp_status), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .rx_activity(rx_activity), .tx_activity(tx_activity),
    .suspend_state(suspend_state), .clk_ref(clk_ref), .converter_input_1(converter_input_1),
    .converter_input_2(converter_input_2),
    .analog_output_1(analog_output_1), .conv_ref_sel(conv_ref_sel),
    .internal_converter_reference(internal_converter_reference), .usb_vid(usb_vid), .usb_pid(usb_pid),
    .usb_power_attr(usb_power_attr), .usb_current_ma(usb_current_ma), .password(password),
    .settings_loaded(settings_loaded), .irq(irq));
  psw_host_model u_host (.clk(clk), .pkt_ready(pkt_ready), .resp_valid(resp_valid),
    .resp_status(resp_status), .pkt_valid(pkt_valid), .pkt_data(pkt_data), .pkt_last(pkt_last));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim();
    if (err_total == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Waitrequest is sampled at the rising edge, the same edge at which the slave accepts
  task automatic bus(input logic [2:0] a, input logic wr, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= wd;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    chk("bus_ack", avs_waitrequest, 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (pkt_ready !== 1'b1 && n < 100);
    chk("ready", pkt_ready, 1'b1);
  endtask
  // Stored values only reach the outputs through a fresh load
  task automatic reload();
    logic [31:0] rd;
    bus(REG_CONTROL, 1'b1, 32'h1, rd);
    repeat (2) @(posedge clk);
    wait_ready();
    // Pin outputs follow the applied levels one edge later
    @(negedge clk);
  endtask
  task automatic edge_test(input logic v, input logic e_irq, input logic [2:0] e_st);
    logic [31:0] rd;
    int n;
    n = 0;
    @(posedge clk);
    pin_in[1] <= v;
    do begin
      @(negedge clk);
      n++;
    end while (irq !== 1'b1 && n < 10);
    chk("irq", irq, e_irq);
    bus(REG_STATUS, 1'b0, 32'h0, rd);
    chk("status", rd[2:0], e_st);
    bus(REG_GPIO_IN, 1'b0, 32'h0, rd);
    chk("pin_in", rd, {30'h0, v, 1'b0});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (40000) @(posedge clk);
    err_total++;
    end_sim();
  end
  initial begin
    logic [31:0] rd;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    wait_ready();
    chk("loaded", settings_loaded, 1'b1);
    chk("blank_oe", pin_oe_n, 3'b000);
    bus(REG_MASK, 1'b0, 32'h0, rd);
    chk("mask_rst", rd, 32'h0);
    bus(3'h7, 1'b1, 32'hffffffff, rd);
    bus(3'h7, 1'b0, 32'h0, rd);
    chk("unmapped", rd, 32'h0);
    // Distinct source levels show which source each pin follows
    rx_activity <= 1'b1;
    clk_ref <= 1'b1;
    // Every function code on all three pins, undefined codes included
    for (int c = 0; c < 8; c++) begin
      u_host.gp(8'(c), 8'(c), 8'(c));
      chk("resp", {u_host.resp_n, u_host.resp_code}, 16'h0100);
      reload();
      chk("oe0", pin_oe_n[0], c > 2);
      chk("oe1", pin_oe_n[1], !(c == 0 || c == 1 || c == 3));
      chk("oe2", pin_oe_n[2], c > 1);
      chk("conv1", converter_input_1, c == 2);
      chk("conv2", converter_input_2, c == 2);
      chk("analog", analog_output_1, c == 3);
      chk("pin_out", pin_out, (c == 1) ? 3'b111 : 3'b000);
    end
    u_host.gp(8'hf0, 8'h04, 8'h18);
    reload();
    chk("oe", pin_oe_n, 3'b110);
    chk("level", pin_out[0], 1'b1);
    bus(REG_GPIO_OUT, 1'b0, 32'h0, rd);
    chk("gpio_out", rd, 32'h5);
    u_host.chip(SUB_CHIP, 8'hf7, 16'h1a2b, 16'h3c4d, 8'h80, 8'hfa, 64'h8877665544332211);
    chk("resp", {u_host.resp_n, u_host.resp_code}, 16'h0100);
    reload();
    chk("ref_sel", conv_ref_sel, 2'b10);
    chk("ref_int", internal_converter_reference, 1'b1);
    chk("vid", usb_vid, 16'h1a2b);
    chk("pid", usb_pid, 16'h3c4d);
    chk("power", usb_power_attr, 8'h80);
    chk("current", usb_current_ma, 9'h1f4);
    chk("password", password, 64'h8877665544332211);
    bus(REG_IDS, 1'b0, 32'h0, rd);
    chk("ids", rd, 32'h3c4d1a2b);
    bus(REG_POWER, 1'b0, 32'h0, rd);
    chk("power_reg", rd, 32'h000efa80);
    bus(REG_STATUS, 1'b0, 32'h0, rd);
    chk("stored", rd[2:0], 3'h2);
    bus(REG_MASK, 1'b1, 32'h1, rd);
    edge_test(1'b1, 1'b1, 3'h1);
    edge_test(1'b0, 1'b1, 3'h1);
    u_host.chip(SUB_CHIP, 8'h84, 16'h1a2b, 16'h3c4d, 8'h80, 8'hfa, 64'h0);
    reload();
    chk("ref_off", conv_ref_sel, 2'b00);
    bus(REG_STATUS, 1'b0, 32'h0, rd);
    edge_test(1'b1, 1'b0, 3'h0);
    edge_test(1'b0, 1'b0, 3'h0);
    u_host.chip(SUB_CHIP, 8'h40, 16'h1a2b, 16'h3c4d, 8'h80, 8'hfa, 64'h0);
    reload();
    chk("ref_vdd", internal_converter_reference, 1'b0);
    bus(REG_STATUS, 1'b0, 32'h0, rd);
    edge_test(1'b1, 1'b0, 3'h0);
    bus(REG_MASK, 1'b1, 32'h0, rd);
    edge_test(1'b0, 1'b0, 3'h1);
    u_host.chip(8'h05, 8'h00, 16'h0, 16'h0, 8'h0, 8'h0, 64'h0);
    chk("unsup", {u_host.resp_n, u_host.resp_code}, {8'h01, u_psw_top.RESP_UNSUPPORTED});
    bus(REG_STATUS, 1'b0, 32'h0, rd);
    chk("unsup_flag", rd[STAT_UNSUP], 1'b1);
    u_host.pkt_q[0] = 8'ha0;
    u_host.send();
    chk("no_resp", u_host.resp_n, 8'h00);
    end_sim();
  end
endmodule
